/* File: core/wot_consts.svh */
`ifndef WOT_CONSTS_SVH
`define WOT_CONSTS_SVH

`define WOT_AW 8
`define WOT_REG_CTRL 8'h00
`define WOT_REG_SRC 8'h04
`define WOT_REG_DIVISOR 8'h08
`define WOT_REG_DELAY 8'h0c
`define WOT_REG_COUNT 8'h10
`define WOT_REG_CMD 8'h14
`define WOT_REG_STATUS 8'h18
`define WOT_REG_ISSUED 8'h1c

`define WOT_CMD_START 0
`define WOT_CMD_STOP 1
`define WOT_STAT_RUNNING 0
`define WOT_STAT_PAUSED 1
`define WOT_STAT_DONE 2

`define WOT_CTRL_RST 32'h0000_0000
`define WOT_SRC_RST 32'h0000_0000
`define WOT_DIVISOR_RST 24'h000002
`define WOT_DELAY_RST 24'h000002
`define WOT_COUNT_RST 24'h000001

`define WOT_START_SW 2'h0
`define WOT_START_DIG 2'h1
`define WOT_START_CMP 2'h2
`define WOT_PAUSE_OFF 2'h0
`define WOT_PAUSE_DIG 2'h1
`define WOT_PAUSE_CMP 2'h2
`define WOT_TB_FAST 2'h0
`define WOT_TB_SLOW 2'h1

`define WOT_CLK_HZ 100000000
`define WOT_FAST_HZ 20000000
`define WOT_SLOW_HZ 100000
`define WOT_FAST_DIV (`WOT_CLK_HZ / `WOT_FAST_HZ)
`define WOT_SLOW_DIV (`WOT_FAST_HZ / `WOT_SLOW_HZ)
`endif

/* File: core/wot_pkg.sv */
package wot_pkg;
    typedef enum logic [1:0] {
        WOT_IDLE = 2'b00,
        WOT_ARMED = 2'b01,
        WOT_DELAY = 2'b11,
        WOT_RUN = 2'b10
    } wot_state_t;

    typedef struct packed {
        logic [16:0] rsvd;
        logic [1:0] tb_mode;
        logic uclk_ext;
        logic [1:0] pause_mode;
        logic [1:0] start_mode;
        logic tb_fall;
        logic uclk_fall;
        logic pause_low;
        logic start_fall;
        logic finite;
        logic root_ext;
        logic uclk_oe;
        logic start_oe;
    } wot_ctrl_t;

    typedef struct packed {
        logic [2:0] rsvd3;
        logic [4:0] tb;
        logic [2:0] rsvd2;
        logic [4:0] uclk;
        logic [2:0] rsvd1;
        logic [4:0] pause;
        logic [2:0] rsvd0;
        logic [4:0] start;
    } wot_src_t;
endpackage

/* File: core/wot_engine.sv */
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "wot_consts.svh"

module wot_engine import wot_pkg::*; #(
    parameter int N_PFI = 10,
    parameter int N_CH = 2,
    parameter int CW = 24
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [`WOT_AW-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [N_PFI-1:0] pfi_i,
    input wire logic [7:0] bus_line_i,
    input wire logic cmp_event_i,
    input wire logic gp_counter_out_i,
    output logic [N_CH-1:0] dac_update_o,
    output logic start_trigger_pin_o,
    output logic start_trigger_pin_oe_o,
    output logic update_clock_pin_o,
    output logic update_clock_pin_oe_o,
    output logic root_tick_o
);
    localparam int NX = N_PFI + 9;

    if (N_PFI < 7 || N_PFI + 11 > 32 || N_CH < 1 || CW < 2 || CW > 32) begin : g_bad_params
        $error("wot_engine: unsupported parameter values");
    end

    function automatic logic edge_of(input logic cur, input logic prev, input logic fall);
        edge_of = fall ? (prev & ~cur) : (cur & ~prev);
    endfunction

    // A programmed zero would stall the divider forever, so it acts as one.
    function automatic logic [CW-1:0] at_least_one(input logic [CW-1:0] v);
        at_least_one = (v == '0) ? CW'(1) : v;
    endfunction

    wot_ctrl_t ctrl_ff;
    wot_src_t src_ff;
    wot_state_t state_ff;
    logic [CW-1:0] divisor_ff, delay_ff, count_ff, cnt_ff, issued_ff;
    logic [NX-1:0] s1_ff, s2_ff, s3_ff, lvl_ff;
    logic [2:0] fast_cnt_ff;
    logic [7:0] slow_cnt_ff;
    logic bus7_prev_ff, root_tick_ff, slow_tick_ff;
    logic start_prev_ff, cmp_prev_ff, uclk_prev_ff, tb_prev_ff;
    logic div_pulse_ff, done_ff;
    logic [31:0] src_vec;
    logic root_tick, tb_tick, sw_start, sw_stop, trig_edge, start_evt;
    logic uclk_lvl, uclk_evt, sample_evt, pause_now, issue, finite_end, div_fire;
    logic tb_lvl, start_lvl, pause_lvl, cmp_lvl;
    wot_state_t go_state;

    // Pins and bus lines are asynchronous: a bit moves only when stages two and three agree.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            lvl_ff <= '0;
        end else begin
            s1_ff <= {cmp_event_i, bus_line_i, pfi_i};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= (s2_ff & s3_ff) | (lvl_ff & (s2_ff ^ s3_ff));
        end
    end

    assign cmp_lvl = lvl_ff[N_PFI+8];

    assign root_tick = ctrl_ff.root_ext ? (lvl_ff[N_PFI+7] & ~bus7_prev_ff)
                                        : (fast_cnt_ff == 3'(`WOT_FAST_DIV - 1));

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fast_cnt_ff <= 3'h0;
            bus7_prev_ff <= 1'b0;
            root_tick_ff <= 1'b0;
            slow_cnt_ff <= 8'h00;
            slow_tick_ff <= 1'b0;
        end else begin
            fast_cnt_ff <= (fast_cnt_ff == 3'(`WOT_FAST_DIV - 1)) ? 3'h0 : fast_cnt_ff + 3'h1;
            bus7_prev_ff <= lvl_ff[N_PFI+7];
            root_tick_ff <= root_tick;
            slow_tick_ff <= 1'b0;
            if (root_tick) begin
                if (slow_cnt_ff == 8'(`WOT_SLOW_DIV - 1)) begin
                    slow_cnt_ff <= 8'h00;
                    slow_tick_ff <= 1'b1;
                end else begin
                    slow_cnt_ff <= slow_cnt_ff + 8'h01;
                end
            end
        end
    end

    always_comb begin
        src_vec = '0;
        src_vec[N_PFI-1:0] = lvl_ff[N_PFI-1:0];
        src_vec[N_PFI+:7] = lvl_ff[N_PFI+:7];
        src_vec[N_PFI+7] = cmp_lvl;
        src_vec[N_PFI+8] = root_tick_ff;
        src_vec[N_PFI+9] = slow_tick_ff;
        src_vec[N_PFI+10] = gp_counter_out_i;
    end

    assign start_lvl = src_vec[src_ff.start];
    assign pause_lvl = src_vec[src_ff.pause];
    assign tb_lvl = src_vec[src_ff.tb];

    always_comb begin
        if (ctrl_ff.tb_mode == `WOT_TB_FAST) begin
            tb_tick = root_tick_ff;
        end else if (ctrl_ff.tb_mode == `WOT_TB_SLOW) begin
            tb_tick = slow_tick_ff;
        end else begin
            tb_tick = edge_of(tb_lvl, tb_prev_ff, ctrl_ff.tb_fall);
        end
    end

    assign sw_start = wr_i && (addr_i == `WOT_REG_CMD) && wdata_i[`WOT_CMD_START];
    assign sw_stop = wr_i && (addr_i == `WOT_REG_CMD) && wdata_i[`WOT_CMD_STOP];

    // digital start edge; comparator rising edge.
    always_comb begin
        if (ctrl_ff.start_mode == `WOT_START_DIG) begin
            trig_edge = edge_of(start_lvl, start_prev_ff, ctrl_ff.start_fall);
        end else if (ctrl_ff.start_mode == `WOT_START_CMP) begin
            trig_edge = cmp_lvl & ~cmp_prev_ff;
        end else begin
            trig_edge = 1'b0;
        end
    end

    assign start_evt = !sw_stop && (((state_ff == WOT_IDLE) && sw_start
                        && (ctrl_ff.start_mode == `WOT_START_SW))
                        || ((state_ff == WOT_ARMED) && trig_edge));
    assign go_state = ctrl_ff.uclk_ext ? WOT_RUN : WOT_DELAY;

    always_comb begin
        if (ctrl_ff.pause_mode == `WOT_PAUSE_DIG) begin
            pause_now = pause_lvl ^ ctrl_ff.pause_low;
        end else if (ctrl_ff.pause_mode == `WOT_PAUSE_CMP) begin
            pause_now = cmp_lvl;
        end else begin
            pause_now = 1'b0;
        end
    end

    assign uclk_lvl = ctrl_ff.uclk_ext ? src_vec[src_ff.uclk] : div_pulse_ff;
    assign uclk_evt = edge_of(uclk_lvl, uclk_prev_ff, ctrl_ff.uclk_fall);
    assign sample_evt = uclk_evt && (state_ff == WOT_RUN);
    // pause masks samples; decided at each sample start only.
    assign issue = sample_evt && !pause_now;
    assign finite_end = ctrl_ff.finite && issue && (issued_ff + CW'(1) >= at_least_one(count_ff));
    assign div_fire = !ctrl_ff.uclk_ext && tb_tick && (cnt_ff <= CW'(1))
                      && ((state_ff == WOT_DELAY) || (state_ff == WOT_RUN));

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            start_prev_ff <= 1'b0;
            cmp_prev_ff <= 1'b0;
            uclk_prev_ff <= 1'b0;
            tb_prev_ff <= 1'b0;
        end else begin
            start_prev_ff <= start_lvl;
            cmp_prev_ff <= cmp_lvl;
            uclk_prev_ff <= uclk_lvl;
            tb_prev_ff <= tb_lvl;
        end
    end

    // start, finite stop and software stop.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff <= WOT_IDLE;
        end else if (sw_stop) begin
            state_ff <= WOT_IDLE;
        end else begin
            case (state_ff)
                WOT_IDLE: begin
                    if (start_evt) begin
                        state_ff <= go_state;
                    end else if (sw_start) begin
                        state_ff <= WOT_ARMED;
                    end
                end
                WOT_ARMED: begin
                    if (start_evt) begin
                        state_ff <= go_state;
                    end
                end
                WOT_DELAY: begin
                    if (div_fire) begin
                        state_ff <= WOT_RUN;
                    end
                end
                default: begin
                    if (finite_end) begin
                        state_ff <= WOT_IDLE;
                    end
                end
            endcase
        end
    end

    // first pulse after the delay; reload and hold.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_ff <= CW'(`WOT_DELAY_RST);
            div_pulse_ff <= 1'b0;
        end else begin
            div_pulse_ff <= div_fire && !sw_stop;
            if (start_evt) begin
                cnt_ff <= at_least_one(delay_ff);
            end else if (div_fire) begin
                cnt_ff <= at_least_one(divisor_ff);
            end else if (tb_tick && !ctrl_ff.uclk_ext
                         && ((state_ff == WOT_DELAY) || (state_ff == WOT_RUN))) begin
                cnt_ff <= cnt_ff - CW'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            issued_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            if (start_evt) begin
                issued_ff <= '0;
            end else if (issue) begin
                issued_ff <= issued_ff + CW'(1);
            end
            // A completion in the clearing cycle keeps the flag set.
            if (finite_end) begin
                done_ff <= 1'b1;
            end else if (wr_i && (addr_i == `WOT_REG_STATUS) && wdata_i[`WOT_STAT_DONE]) begin
                done_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dac_update_o <= '0;
            start_trigger_pin_o <= 1'b0;
            start_trigger_pin_oe_o <= 1'b0;
            update_clock_pin_o <= 1'b0;
            update_clock_pin_oe_o <= 1'b0;
            root_tick_o <= 1'b0;
        end else begin
            dac_update_o <= {N_CH{issue}};
            // start pin echoes the trigger; input until enabled.
            start_trigger_pin_o <= start_evt && ctrl_ff.start_oe;
            start_trigger_pin_oe_o <= ctrl_ff.start_oe;
            // update pin echoes the update clock.
            update_clock_pin_o <= sample_evt && ctrl_ff.uclk_oe;
            update_clock_pin_oe_o <= ctrl_ff.uclk_oe;
            // root timebase always goes out to the counters, ungated.
            root_tick_o <= root_tick_ff;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_ff <= `WOT_CTRL_RST;
            src_ff <= `WOT_SRC_RST;
            divisor_ff <= CW'(`WOT_DIVISOR_RST);
            delay_ff <= CW'(`WOT_DELAY_RST);
            count_ff <= CW'(`WOT_COUNT_RST);
        end else if (wr_i) begin
            if (addr_i == `WOT_REG_CTRL) begin
                ctrl_ff <= {17'h00000, wdata_i[14:0]};
            end else if (addr_i == `WOT_REG_SRC) begin
                src_ff <= wdata_i & 32'h1f1f_1f1f;
            end else if (addr_i == `WOT_REG_DIVISOR) begin
                divisor_ff <= wdata_i[CW-1:0];
            end else if (addr_i == `WOT_REG_DELAY) begin
                delay_ff <= wdata_i[CW-1:0];
            end else if (addr_i == `WOT_REG_COUNT) begin
                count_ff <= wdata_i[CW-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (!rd_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (addr_i == `WOT_REG_CTRL) begin
            rdata_o <= ctrl_ff;
        end else if (addr_i == `WOT_REG_SRC) begin
            rdata_o <= src_ff;
        end else if (addr_i == `WOT_REG_DIVISOR) begin
            rdata_o <= 32'(divisor_ff);
        end else if (addr_i == `WOT_REG_DELAY) begin
            rdata_o <= 32'(delay_ff);
        end else if (addr_i == `WOT_REG_COUNT) begin
            rdata_o <= 32'(count_ff);
        end else if (addr_i == `WOT_REG_STATUS) begin
            rdata_o <= {29'h0, done_ff, pause_now, state_ff != WOT_IDLE};
        end else if (addr_i == `WOT_REG_ISSUED) begin
            rdata_o <= 32'(issued_ff);
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    AST_ALL_CHANNELS: assert property ((dac_update_o == '0) || (dac_update_o == '1))
        else $error("converter updates not simultaneous");
    AST_SW_START: assert property ((state_ff == WOT_IDLE) && sw_start && !sw_stop
        && (ctrl_ff.start_mode == `WOT_START_SW) |=> (state_ff == WOT_DELAY) || (state_ff == WOT_RUN))
        else $error("software start ignored");
    AST_CMP_START: assert property ((state_ff == WOT_ARMED) && !sw_stop
        && (ctrl_ff.start_mode == `WOT_START_CMP) && cmp_lvl && !cmp_prev_ff
        |=> state_ff != WOT_ARMED)
        else $error("comparator edge did not start");
    AST_START_PIN: assert property (start_evt |=> start_trigger_pin_o == start_trigger_pin_oe_o)
        else $error("start pin did not echo trigger");
    AST_START_PIN_IN: assert property (!ctrl_ff.start_oe |=> !start_trigger_pin_oe_o && !start_trigger_pin_o)
        else $error("start pin driven while input");
    AST_PAUSE_MASK: assert property (sample_evt && pause_now |=> dac_update_o == '0)
        else $error("sample issued during pause");
    AST_SAMPLE_ISSUE: assert property (sample_evt && !pause_now |=> dac_update_o == '1)
        else $error("unpaused sample lost");
    AST_UCLK_PIN: assert property (sample_evt && ctrl_ff.uclk_oe |=> update_clock_pin_o)
        else $error("update pin did not pulse");
    AST_FINITE_STOP: assert property (finite_end |=> state_ff == WOT_IDLE ##1 dac_update_o == '0)
        else $error("finite generation did not stop");
    AST_DELAY_RUN: assert property (div_fire && (state_ff == WOT_DELAY) && !sw_stop
        |=> (state_ff == WOT_RUN) && div_pulse_ff)
        else $error("delay expiry did not start run");
    AST_RELOAD: assert property (div_fire && !start_evt |=> cnt_ff == at_least_one($past(divisor_ff)))
        else $error("divisor not reloaded");
    AST_HOLD: assert property ((state_ff == WOT_IDLE) && !start_evt |=> $stable(cnt_ff))
        else $error("divider moved while stopped");

    COV_INTERNAL_RUN: cover property (state_ff == WOT_DELAY ##[1:300] dac_update_o == '1);
    COV_PAUSED_SAMPLE: cover property (sample_evt && pause_now);
    COV_FINITE_DONE: cover property (finite_end);
    COV_ARMED_START: cover property ((state_ff == WOT_ARMED) ##1 (state_ff == WOT_RUN));
endmodule

/* File: bench/wot_far_side.sv */
`timescale 1ns/1ps
module wot_far_side (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [1:0] dac_update_i,
    output logic [9:0] pfi_o,
    output logic [7:0] bus_line_o,
    output logic cmp_event_o
);
    // Lines 0-9 function pins, 10-16 bus lines 0-6, 17 comparator, 18 bus line 7.
    logic [18:0] src_ff = '0;
    int cyc = 0;
    int n_conv = 0;
    int n_skew = 0;
    int t_upd[$];
    int t_edge = 0;
    assign pfi_o = src_ff[9:0];
    assign bus_line_o = {src_ff[18], src_ff[16:10]};
    assign cmp_event_o = src_ff[17];
    always @(posedge sys_clk_i) begin
        cyc++;
        if (rstn_i && dac_update_i[0]) begin
            n_conv++;
            t_upd.push_back(cyc);
        end
        if (dac_update_i[0] !== dac_update_i[1]) n_skew++;
    end
    task automatic clear;
        n_conv = 0;
        t_upd.delete();
    endtask
    task automatic drive(input int idx, input logic lvl);
        @(posedge sys_clk_i);
        src_ff[idx] <= lvl;
        t_edge = cyc;
    endtask
    // Low time equals high time so the synchroniser sees both levels.
    task automatic pulse(input int idx, input int hi);
        drive(idx, 1'b1);
        repeat (hi) @(posedge sys_clk_i);
        src_ff[idx] <= 1'b0;
        repeat (hi) @(posedge sys_clk_i);
    endtask
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`include "wot_consts.svh"
module tb_top import wot_pkg::*; ;
    logic sys_clk_i, rstn_i, wr_i, rd_i, cmp, st_o, st_oe, uc_o, uc_oe, root_tick;
    logic [7:0] addr_i, bus;
    logic [31:0] wdata_i, rdata_o, d;
    logic [9:0] programmable_function_pin;
    logic [1:0] dac;
    int failures, n_tests, n_spin, n_upin, n_root, cyc_cnt, t0, lat;
    wot_ctrl_t c;
    wot_src_t s;
    wot_engine DUT (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pfi_i(programmable_function_pin),
        .bus_line_i(bus), .cmp_event_i(cmp), .gp_counter_out_i(1'b0), .dac_update_o(dac),
        .start_trigger_pin_o(st_o), .start_trigger_pin_oe_o(st_oe),
        .update_clock_pin_o(uc_o), .update_clock_pin_oe_o(uc_oe), .root_tick_o(root_tick));
    wot_far_side u_far (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .dac_update_i(dac),
        .pfi_o(programmable_function_pin), .bus_line_o(bus), .cmp_event_o(cmp));
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc_cnt++;
        if (st_o === 1'b1) n_spin++;
        if (uc_o === 1'b1) n_upin++;
        if (root_tick === 1'b1) n_root++;
        if (cyc_cnt == 10000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("failures %0d n_tests %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    task automatic clr;
        #1 u_far.clear();
        n_spin = 0;
        n_upin = 0;
        n_root = 0;
    endtask
    task automatic cfg;
        wr(`WOT_REG_CTRL, c);
        wr(`WOT_REG_SRC, s);
        clr();
    endtask
    task automatic t_reset;
        logic [7:0] a[6] = '{`WOT_REG_CTRL, `WOT_REG_SRC, `WOT_REG_DIVISOR,
            `WOT_REG_DELAY, `WOT_REG_COUNT, 8'h20};
        logic [31:0] e[6] = '{32'h0, 32'h0, 32'h2, 32'h2, 32'h1, 32'h0};
        check("start_oe", st_oe, 1'b0);
        check("uclk_oe", uc_oe, 1'b0);
        wr(8'h20, 32'hffffffff);
        for (int i = 0; i < 6; i++) begin
            rd(a[i], d);
            check("reset", d, e[i]);
        end
        wr(`WOT_REG_CTRL, 32'hffff8000);
        rd(`WOT_REG_CTRL, d);
        check("ctrl_rsvd", d, 32'h0);
    endtask
    task automatic t_finite(input int dl);
        c = '0;
        s = '0;
        c.start_oe = 1'b1;
        c.uclk_oe = 1'b1;
        c.finite = 1'b1;
        wr(`WOT_REG_COUNT, 32'h3);
        wr(`WOT_REG_DELAY, dl);
        cfg();
        check("st_oe_on", st_oe, 1'b1);
        check("uc_oe_on", uc_oe, 1'b1);
        wr(`WOT_REG_CMD, 32'h1);
        #1 t0 = u_far.cyc;
        repeat (5 * dl + 40) @(posedge sys_clk_i);
        check("n_conv", u_far.n_conv, 3);
        check("n_upin", n_upin, 3);
        check("n_spin", n_spin, 1);
        lat = u_far.t_upd[0] - t0;
        check("first", lat >= 5 * dl - 2 && lat <= 5 * dl + 2, 1'b1);
        check("gap0", u_far.t_upd[1] - u_far.t_upd[0], 10);
        check("gap1", u_far.t_upd[2] - u_far.t_upd[1], 10);
        rd(`WOT_REG_STATUS, d);
        check("done", d[2:0], 3'b100);
        rd(`WOT_REG_ISSUED, d);
        check("issued", d, 32'h3);
        wr(`WOT_REG_STATUS, 32'h4);
    endtask
    task automatic t_trig;
        int idx[4] = '{3, 10, 16, 17};
        for (int i = 0; i < 4; i++) begin
            c = '0;
            s = '0;
            c.start_oe = 1'b1;
            c.finite = 1'b1;
            c.start_mode = (i == 3) ? 2'h2 : 2'h1;
            c.start_fall = (i == 2);
            s.start = 5'(idx[i]);
            wr(`WOT_REG_COUNT, 32'h1);
            cfg();
            wr(`WOT_REG_CMD, 32'h1);
            repeat (30) @(posedge sys_clk_i);
            check("armed_conv", u_far.n_conv, 0);
            u_far.pulse(idx[i], 6);
            repeat (50) @(posedge sys_clk_i);
            check("trig_spin", n_spin, 1);
            check("trig_conv", u_far.n_conv, 1);
            wr(`WOT_REG_STATUS, 32'h4);
        end
    endtask
    task automatic t_pause(input logic [1:0] md, input logic lo, input int idx, input logic lv);
        c = '0;
        s = '0;
        c.pause_mode = md;
        c.pause_low = lo;
        c.uclk_oe = 1'b1;
        s.pause = 5'(idx);
        u_far.drive(idx, lv);
        cfg();
        wr(`WOT_REG_CMD, 32'h1);
        repeat (100) @(posedge sys_clk_i);
        check("paused_conv", u_far.n_conv, 0);
        check("paused_upin", n_upin > 5, 1'b1);
        rd(`WOT_REG_STATUS, d);
        check("paused_stat", d[1:0], 2'b11);
        u_far.drive(idx, ~lv);
        repeat (100) @(posedge sys_clk_i);
        check("resumed", u_far.n_conv > 5, 1'b1);
        wr(`WOT_REG_CMD, 32'h2);
        rd(`WOT_REG_STATUS, d);
        check("stopped", d[0], 1'b0);
    endtask
    task automatic t_ext;
        for (int f = 0; f < 2; f++) begin
            c = '0;
            s = '0;
            c.uclk_ext = 1'b1;
            c.uclk_oe = 1'b1;
            c.uclk_fall = 1'(f);
            s.uclk = 5'(f ? 12 : 4);
            cfg();
            wr(`WOT_REG_CMD, 32'h1);
            repeat (3) u_far.pulse(f ? 12 : 4, 6);
            repeat (2) @(posedge sys_clk_i);
            check("ext_conv", u_far.n_conv, 3);
            check("ext_upin", n_upin, 3);
            lat = u_far.t_upd[2] - u_far.t_edge;
            check("ext_edge", lat >= 8, f);
            wr(`WOT_REG_CMD, 32'h2);
        end
    endtask
    task automatic t_clocks;
        c = '0;
        s = '0;
        c.tb_mode = `WOT_TB_SLOW;
        wr(`WOT_REG_DIVISOR, 32'h1);
        wr(`WOT_REG_DELAY, 32'h1);
        cfg();
        wr(`WOT_REG_CMD, 32'h1);
        repeat (2100) @(posedge sys_clk_i);
        check("slow_gap", u_far.t_upd[1] - u_far.t_upd[0], `WOT_CLK_HZ / `WOT_SLOW_HZ);
        wr(`WOT_REG_CMD, 32'h2);
        c.tb_mode = 2'h2;
        s.tb = 5'h07;
        cfg();
        wr(`WOT_REG_CMD, 32'h1);
        repeat (3) u_far.pulse(7, 6);
        repeat (2) @(posedge sys_clk_i);
        check("tb_pin", u_far.n_conv, 3);
        wr(`WOT_REG_CMD, 32'h2);
        wr(`WOT_REG_DIVISOR, 32'h2);
        clr();
        repeat (200) @(posedge sys_clk_i);
        check("root_fast", n_root, 40);
        c = '0;
        c.root_ext = 1'b1;
        cfg();
        repeat (4) u_far.pulse(18, 3);
        repeat (2) @(posedge sys_clk_i);
        check("root_ext", n_root, 4);
    endtask
    initial begin
        rstn_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = '0;
        wdata_i = '0;
        repeat (16) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        t_reset();
        t_finite(2);
        t_finite(4);
        t_trig();
        t_pause(`WOT_PAUSE_DIG, 1'b0, 1, 1'b1);
        t_pause(`WOT_PAUSE_DIG, 1'b1, 1, 1'b0);
        t_pause(`WOT_PAUSE_CMP, 1'b0, 17, 1'b1);
        t_ext();
        t_clocks();
        check("skew", u_far.n_skew, 0);
        print_verdict();
    end
endmodule
